// >>> rtl/pors_cfg.svh
`ifndef PORS_CFG_SVH
`define PORS_CFG_SVH
// Clock period in ps (125 MHz)
`define PORS_CLK_PS          8000
// Undervoltage release hysteresis, least time in ns
`define PORS_HYST_NS         30000
`define PORS_HYST_CYC        \
    ((`PORS_HYST_NS * 1000 + `PORS_CLK_PS - 1) / `PORS_CLK_PS)
// Regulator soft start duration in ns
`define PORS_SOFT_NS         1000000
`define PORS_SOFT_CYC        (`PORS_SOFT_NS * 1000 / `PORS_CLK_PS)
// Firmware runtime budget in ns (external supply mode)
`define PORS_FW_NS           1100000
`define PORS_FW_CYC          (`PORS_FW_NS * 1000 / `PORS_CLK_PS)
// Ports inactive after power-on reset, longest time in ns
`define PORS_PIP_NS          150
`define PORS_PIP_CYC         (`PORS_PIP_NS * 1000 / `PORS_CLK_PS)
// Ports inactive after external system reset, in bus clock periods
`define PORS_ESR_PB          8
// Supply mode code on config pins 0 and 2
`define PORS_MODE_SINGLE     2'b10
// Default user clock in MHz
`define PORS_USER_MHZ        100
`endif

// >>> rtl/pors_pkg.sv
package pors_pkg;
    // Sequencer phases
    typedef enum logic [2:0]
    {
        PORS_RESET = 3'b000,
        PORS_SOFT  = 3'b001,
        PORS_HYST  = 3'b010,
        PORS_FW    = 3'b011,
        PORS_USER  = 3'b100
    } pors_phase_type;
endpackage

// >>> rtl/pors_timer.sv
`include "pors_cfg.svh"
// Down counter: loads a count, holds done once it reaches zero
module pors_timer #(
    parameter int WIDTH = 20
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    // Control
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] count_in,
    input  wire logic             run_in,
    // Status
    output logic                  done_out
);
    // ****************************************************
    // Counter
    // ****************************************************
    logic [WIDTH-1:0] cnt_q;    // Remaining cycles
    logic             armed_q;  // Count loaded since reset, stays set

    // Narrow counters cannot count; wider ones overflow an int count
    if (WIDTH < 2 || WIDTH > 31)
        $error("pors_timer: WIDTH out of range");

    // Count down while running; done stands once zero is reached
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || load_in)
        begin
            cnt_q   <= sys_rst_in ? '0 : count_in;
            armed_q <= !sys_rst_in;
        end
        else if (run_in && armed_q && cnt_q != '0)
        begin
            cnt_q <= cnt_q - WIDTH'(1);
        end
    end

    assign done_out = armed_q && (cnt_q == '0);
endmodule

// >>> rtl/pors_seq.sv
`include "pors_cfg.svh"
// Overview of operation
// R1: Reset active if pin pulled low or driven
// R2: Drive reset low on any undervoltage
// R3: Release only with supplies good and clock ready
// R4: Single supply: decode mode, soft start regulator
// R5: On reset rise capture config pins, start firmware
// R6: After firmware run user code at 100 MHz
// R7: Outside holds pin low until supplies good
// R8: First user instruction within 350 us of app reset
// R9: First user instruction within 1 ms of system reset
// R10: Power-on boot 2.5 ms; firmware 1.1 ms
// R11: Outside holds reset 1 ms after supplies settle
// R12: Config pins stable 16 bus clocks after rise
// R13: Ports inactive within 8 bus clocks of system reset
// R14: Ports inactive within 150 ns of power-on reset
// R15: Outside asserts reset 100 us before power fail
// R16: Release delayed 30-60 us after threshold crossed
// R17: Synchronous inputs; phases reset, firmware, user
module pors_seq
#(
    parameter int HYST_CYC = `PORS_HYST_CYC,
    parameter int SOFT_CYC = `PORS_SOFT_CYC,
    parameter int FW_CYC   = `PORS_FW_CYC
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // Supply and clock status
    input  wire logic       uv_core_in,
    input  wire logic       uv_io_in,
    input  wire logic       clk_ready_in,
    input  wire logic       soft_done_in,
    // Power-on reset pin (open drain)
    input  wire logic       power_on_reset_pin_in,
    output logic            power_on_reset_pin_out,
    output logic            power_on_reset_pin_oe_out,
    // External system reset pin, active low, and bus clock enable
    input  wire logic       external_system_reset_pin_n_in,
    input  wire logic       peripheral_bus_clock_en_in,
    // Configuration pins
    input  wire logic [5:0] hardware_config_pins_in,
    // Firmware handshake
    input  wire logic       fw_done_in,
    // Status
    output logic            regulator_soft_start_out,
    output logic            single_supply_out,
    output logic [2:0]      boot_config_out,
    output logic            fw_run_out,
    output logic            user_run_out,
    output logic [7:0]      user_clk_mhz_out,
    output logic            ports_inactive_out,
    output logic            fw_timeout_out,
    output pors_pkg::pors_phase_type phase_out
);
    import pors_pkg::*;

    // Checks at the foot of this module share one clock and reset
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // The timers below are 16 and 20 bits wide
    if (HYST_CYC < 1 || HYST_CYC > 65535 || SOFT_CYC < 1 ||
        SOFT_CYC > 1048575 || FW_CYC < 1 || FW_CYC > 1048575)
        $error("pors_seq: count parameter out of range");

    // ****************************************************
    // Supply monitoring
    // ****************************************************
    logic           uv_any;       // Any rail below threshold
    logic           por_active;   // Combined reset level
    logic           por_prev_q;   // Previous pin level for edge
    logic           drive_q;      // Internal drive of the pin
    logic           mode_q;       // Decoded single supply mode
    logic [2:0]     cfg_q;        // Latched config pins 3..5
    logic           esr_ports_q;  // Ports held by system reset
    logic [3:0]     esr_cnt_q;    // Bus clocks since system reset
    pors_phase_type phase_q;      // Current phase
    pors_phase_type phase_d;      // Next phase
    logic           hyst_done;    // Hysteresis elapsed
    logic           fw_tmo;       // Firmware budget elapsed
    logic           soft_tmo;     // Regulator ramp budget elapsed

    // Mode decode used by phase logic and status output
    function automatic logic is_single(input logic [5:0] c);
        return {c[2], c[0]} == `PORS_MODE_SINGLE;
    endfunction

    assign uv_any     = uv_core_in || uv_io_in;
    // Either source alone holds reset
    assign por_active = !power_on_reset_pin_in || drive_q; // R1

    // ****************************************************
    // Pin drive
    // ****************************************************
    // Drive low on undervoltage at once; release only from hysteresis
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            drive_q <= 1'b1;
        else if (uv_any)
            drive_q <= 1'b1; // R2
        else if (phase_q == PORS_HYST && hyst_done && clk_ready_in)
            drive_q <= 1'b0; // R3 R16
    end

    assign power_on_reset_pin_out    = 1'b0;
    assign power_on_reset_pin_oe_out = drive_q;

    // ****************************************************
    // Timers
    // ****************************************************
    // Hysteresis restarts whenever a rail dips; clock loss only holds off release
    pors_timer #(.WIDTH(16)) u_hyst (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (phase_q != PORS_HYST),
        .count_in   (16'(HYST_CYC)),
        .run_in     (1'b1),
        .done_out   (hyst_done)
    );

    // Firmware budget, used only as a watchdog flag
    pors_timer #(.WIDTH(20)) u_fw (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (phase_q != PORS_FW),
        .count_in   (20'(FW_CYC)),
        .run_in     (1'b1),
        .done_out   (fw_tmo)
    );

    // Regulator ramp budget; done input or budget ends soft start
    pors_timer #(.WIDTH(20)) u_soft (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .load_in    (phase_q != PORS_SOFT),
        .count_in   (20'(SOFT_CYC)),
        .run_in     (1'b1),
        .done_out   (soft_tmo)
    );

    // ****************************************************
    // Phase sequencing
    // ****************************************************
    always_comb
    begin
        phase_d = phase_q;
        unique case (phase_q)
            PORS_RESET:
            begin
                if (!uv_any && clk_ready_in)
                    phase_d = is_single(hardware_config_pins_in)
                              ? PORS_SOFT : PORS_HYST; // R4
            end
            PORS_SOFT:
            begin
                if (soft_done_in || soft_tmo)
                    phase_d = PORS_HYST;
            end
            PORS_HYST:
            begin
                if (!drive_q && power_on_reset_pin_in)
                    phase_d = PORS_FW; // R5
            end
            PORS_FW:
            begin
                // No added latency: user code starts right after firmware
                if (fw_done_in)
                    phase_d = PORS_USER; // R6 R8 R9 R17
            end
            PORS_USER:
            begin
                phase_d = PORS_USER;
            end
            default:
            begin
                phase_d = PORS_RESET;
            end
        endcase
        // Undervoltage, or a reset level once firmware has started, returns the sequence to the start
        if (uv_any || (phase_q >= PORS_FW && por_active))
            phase_d = PORS_RESET; // R17
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            phase_q <= PORS_RESET;
        else
            phase_q <= phase_d;
    end

    // ****************************************************
    // Configuration capture
    // ****************************************************
    // Mode decode when infrastructure is first up
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            mode_q <= 1'b0;
        else if (phase_q == PORS_RESET && !uv_any && clk_ready_in)
            mode_q <= is_single(hardware_config_pins_in); // R4
    end

    // Latch boot config on the reset pin rising edge
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            por_prev_q <= 1'b0;
            cfg_q      <= 3'h0;
        end
        else
        begin
            por_prev_q <= !por_active;
            if (!por_active && !por_prev_q)
                cfg_q <= hardware_config_pins_in[5:3]; // R5
        end
    end

    // ****************************************************
    // Port deactivation
    // ****************************************************
    // System reset: ports go inactive on the next clock edge,
    // well inside the 8 period budget
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            esr_ports_q <= 1'b1;
            esr_cnt_q   <= 4'h0;
        end
        else if (!external_system_reset_pin_n_in)
        begin
            esr_ports_q <= 1'b1; // R13
            esr_cnt_q   <= 4'h0;
        end
        else if (peripheral_bus_clock_en_in && esr_cnt_q != 4'hf)
        begin
            esr_cnt_q <= esr_cnt_q + 4'h1;
            esr_ports_q <= 1'b0;
        end
    end

    // Power-on reset reaches ports combinationally, far below 150 ns
    assign ports_inactive_out = por_active || esr_ports_q; // R14

    // ****************************************************
    // Outputs
    // ****************************************************
    assign regulator_soft_start_out = (phase_q == PORS_SOFT); // R4
    assign single_supply_out        = mode_q;
    assign boot_config_out          = cfg_q;
    assign fw_run_out               = (phase_q == PORS_FW);
    assign user_run_out             = (phase_q == PORS_USER);
    assign user_clk_mhz_out         = user_run_out ? 8'(`PORS_USER_MHZ)
                                                   : 8'h00; // R6
    assign fw_timeout_out           = (phase_q == PORS_FW) && fw_tmo; // R10
    assign phase_out                = phase_q;

    // ****************************************************
    // Checks
    // ****************************************************
    // Cycles spent in hysteresis, saturating, for the release check
    logic [15:0] hyst_age_q;
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || phase_q != PORS_HYST)
            hyst_age_q <= 16'h0000;
        else if (hyst_age_q != 16'hffff)
            hyst_age_q <= hyst_age_q + 16'h0001;
    end
    chk_uv_drive_low: assert property (uv_any |=> drive_q) // R2
        else $error("pin not driven on undervoltage");
    chk_release_cond: assert property ($fell(drive_q) |-> !$past(uv_any) // R3
        && $past(clk_ready_in)) else $error("release without supplies");
    chk_por_combined: assert property (!power_on_reset_pin_in // R1
        && phase_q >= PORS_FW |=> phase_q == PORS_RESET)
        else $error("external reset ignored");
    chk_fw_after_rise: assert property ($rose(fw_run_out) |-> // R5
        $past(power_on_reset_pin_in) && !drive_q)
        else $error("firmware before release");
    chk_user_clock: assert property (user_run_out |-> // R6
        user_clk_mhz_out == 8'h64) else $error("user clock wrong");
    chk_user_order: assert property ($rose(user_run_out) |-> // R17
        $past(phase_q) == PORS_FW) else $error("user without firmware");
    chk_hyst_hold: assert property ($fell(drive_q) |-> // R16
        hyst_age_q >= 16'(HYST_CYC)) else $error("hysteresis too short");
    chk_esr_ports: assert property (!external_system_reset_pin_n_in |=> // R13
        ports_inactive_out) else $error("ports active in system reset");
    chk_soft_single: assert property (regulator_soft_start_out |-> // R4
        mode_q) else $error("soft start in external mode");
    cov_single: cover property ($rose(regulator_soft_start_out));
    cov_user: cover property ($rose(user_run_out));
    cov_pin_user: cover property (user_run_out && !power_on_reset_pin_in);
    cov_fw_tmo: cover property ($rose(fw_timeout_out));
endmodule

// >>> verif/pors_supply.sv
// Model of the outside regulator and reset supervisor
module pors_supply #(
    parameter int HOLD_CYC = 6
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // Bench command and device pin drive
    input  wire logic supply_on_in,
    input  wire logic dev_oe_in,
    // Supply status and pin level
    output logic      uv_core_out,
    output logic      uv_io_out,
    output logic      clk_ready_out,
    output logic      soft_done_out,
    output logic      pin_level_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********************************
    // Rails and reset hold
    // ********************************
    logic       uv_q;    // Rails below threshold
    logic [3:0] hold_q;  // Hold count after rails settle
    logic       pull;    // Supervisor pulls the pin low

    // Rails lag the command, so the pin is pulled first
    always_ff @(posedge clk_in)
    begin
        uv_q <= sys_rst_in | !supply_on_in;
    end

    // Keep pulling for a while after the rails are good
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in || uv_q)
            hold_q <= HOLD_CYC[3:0];
        else if (hold_q != 4'h0)
            hold_q <= hold_q - 4'h1;
    end

    assign pull = uv_q | (hold_q != 4'h0) | !supply_on_in;
    // Pull-up wins only when nobody drives low
    assign pin_level_out = !(pull | dev_oe_in);
    assign uv_core_out = uv_q;
    assign uv_io_out = uv_q;
    assign clk_ready_out = !uv_q;
    // Regulator reports ramped a little before the hold ends
    assign soft_done_out = !uv_q && (hold_q < 4'h3);
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the reset sequencer
module testbench
    import pors_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ********************************
    // Signals
    // ********************************
    logic clk_in = 1'b0;
    logic bus_en = 1'b0;
    logic sys_rst_in, supply_on, esr_n, fw_done;
    logic [1:0] bus_div = 2'h0;
    logic [5:0] cfg;
    logic uv_core, uv_io, clk_ready, soft_done, pin_level, oe;
    logic pin_out, soft_start, single_supply, fw_run, user_run;
    logic ports_inactive, fw_timeout;
    logic [2:0] boot_config;
    logic [7:0] user_clk_mhz;
    pors_phase_type phase;
    pors_phase_type last_phase = PORS_RESET;
    logic [10:0] exp_q[$];  // Expected {phase, clock} per change
    int mismatches, check_count, cycles;

    pors_seq #(.HYST_CYC(4), .SOFT_CYC(8), .FW_CYC(16)) pors_seq_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .uv_core_in(uv_core), .uv_io_in(uv_io),
        .clk_ready_in(clk_ready), .soft_done_in(soft_done),
        .power_on_reset_pin_in(pin_level),
        .power_on_reset_pin_out(pin_out),
        .power_on_reset_pin_oe_out(oe),
        .external_system_reset_pin_n_in(esr_n),
        .peripheral_bus_clock_en_in(bus_en),
        .hardware_config_pins_in(cfg), .fw_done_in(fw_done),
        .regulator_soft_start_out(soft_start),
        .single_supply_out(single_supply),
        .boot_config_out(boot_config), .fw_run_out(fw_run),
        .user_run_out(user_run), .user_clk_mhz_out(user_clk_mhz),
        .ports_inactive_out(ports_inactive),
        .fw_timeout_out(fw_timeout), .phase_out(phase));

    pors_supply pors_supply_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .supply_on_in(supply_on), .dev_oe_in(oe),
        .uv_core_out(uv_core), .uv_io_out(uv_io),
        .clk_ready_out(clk_ready), .soft_done_out(soft_done),
        .pin_level_out(pin_level));

    // ********************************
    // Clock, bus enable, time limit
    // ********************************
    always #4 clk_in = ~clk_in;

    // One enable pulse every fourth cycle
    always @(posedge clk_in)
    begin
        bus_div <= bus_div + 2'h1;
        bus_en <= (bus_div == 2'h0);
    end

    // Cut a hang short
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // Phase watcher takes the oldest note on every change, mid-cycle
    always @(negedge clk_in)
    begin
        if (!sys_rst_in && phase !== last_phase)
        begin
            last_phase <= phase;
            check("phase", {phase, user_clk_mhz},
                  exp_q.size() ? exp_q.pop_front() : 11'h7ff);
        end
    end

    // ********************************
    // Tasks
    // ********************************
    task automatic check(input string what, input logic [10:0] seen,
                         input logic [10:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait for a phase, sampled mid-cycle
    task automatic wait_phase(input pors_phase_type p);
        repeat (300)
        begin
            @(negedge clk_in);
            if (phase === p)
                break;
        end
        check("phase reached", phase, p);
    endtask

    // Power up in one supply mode, then run firmware
    task automatic boot(input logic single, input int fw_wait);
        logic [2:0] top;
        top = 3'($urandom);
        if (single)
            exp_q.push_back({PORS_SOFT, 8'h00});
        exp_q.push_back({PORS_HYST, 8'h00});
        exp_q.push_back({PORS_FW, 8'h00});
        exp_q.push_back({PORS_USER, 8'd100});
        @(posedge clk_in);
        // Mode code sits on pins 2 and 0; pins held all run
        cfg <= {top, single, 1'($urandom), 1'b0};
        supply_on <= 1'b1;
        wait_phase(PORS_FW);
        check("boot config", boot_config, top);
        check("supply mode", single_supply, single);
        check("fw running", fw_run, 1'b1);
        repeat (fw_wait) @(negedge clk_in);
        check("fw overrun", fw_timeout, fw_wait > 16);
        @(posedge clk_in);
        fw_done <= 1'b1;
        wait_phase(PORS_USER);
        check("user running", user_run, 1'b1);
        @(posedge clk_in);
        fw_done <= 1'b0;
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        sys_rst_in = 1'b1;
        supply_on = 1'b0;
        esr_n = 1'b1;
        fw_done = 1'b0;
        cfg = 6'h00;
        void'($urandom(32'hfc8efea6));
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(negedge clk_in);
        check("pin drive", oe, 1'b1);
        boot(1'b1, 5);
        // System reset pulse from outside
        @(posedge clk_in);
        esr_n <= 1'b0;
        repeat (2) @(negedge clk_in);
        check("ports off", ports_inactive, 1'b1);
        @(posedge clk_in);
        esr_n <= 1'b1;
        repeat (12) @(negedge clk_in);
        check("ports on", ports_inactive, 1'b0);
        // Config pins stay put for 16 bus clocks after the rise
        repeat (64) @(posedge clk_in);
        // Power fail: pin pulled first, rails drop next cycle
        exp_q.push_back({PORS_RESET, 8'h00});
        @(posedge clk_in);
        supply_on <= 1'b0;
        @(negedge clk_in);
        check("ports off", ports_inactive, 1'b1);
        repeat (2) @(negedge clk_in);
        check("pin drive", oe, 1'b1);
        check("user stopped", user_run, 1'b0);
        boot(1'b0, 30);
        repeat (2) @(negedge clk_in);
        check("notes left", 11'(exp_q.size()), 11'h000);
        wrap_up();
    end
endmodule
